// ===== bench/serial_switch_output_control_bench.sv
// self-checking bench joining the host and device ends of the switch link
`timescale 1ns/1ps

module serial_switch_output_control_bench;
  import ssoc_pkg::*;

  logic              clk;
  logic              rstn;
  logic [4:0]        av_address;
  logic              av_read;
  logic              av_write;
  logic [31:0]       av_writedata;
  logic [31:0]       av_readdata;
  logic              av_waitrequest;
  logic              force_on;
  logic [WORD_W-1:0] switch_out;
  logic [7:0]        model_reg;  // behavioural copy of the output register
  logic [7:0]        wire_word;  // word seen shifting on the link
  logic [7:0]        w;
  logic [31:0]       rd;
  int                n;
  int                n_errors;
  int                tests_run;

  ssoc_if link_if ();

  ssoc_host ssoc_host_i (.clk(clk), .rstn(rstn), .avs_address(av_address),
    .avs_read(av_read), .avs_write(av_write), .avs_writedata(av_writedata),
    .avs_readdata(av_readdata), .avs_waitrequest(av_waitrequest), .link(link_if.host_mp));
  ssoc_device ssoc_device_i (.clk(clk), .rstn(rstn), .link(link_if.dev_mp),
    .first_output_force_on(force_on), .low_side_switch_output(switch_out));
  ssoc_asserts ssoc_asserts_i (.clk(clk), .rstn(rstn), .select_low(link_if.select_low),
    .serial_clk(link_if.serial_clk), .serial_data(link_if.serial_data),
    .first_output_force_on(force_on), .low_side_switch_output(switch_out));

  // ==================================================================
  // clock and link monitor
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // capture the word msb first as it crosses the wire
  always @(posedge link_if.serial_clk) begin
    if (link_if.select_low === 1'b0) wire_word <= {wire_word[6:0], link_if.serial_data};
  end

  // ==================================================================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // one avalon access, held until waitrequest is sampled low; n counts the edges waited
  // a hung slave is left to the watchdog
  task automatic av_xfer(input logic [4:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    av_address <= a;
    av_write <= wr;
    av_read <= !wr;
    av_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
  endtask : av_xfer

  // poll status until nothing pending or sending, then let outputs land
  task automatic wait_idle();
    do begin
      av_xfer(OFS_STATUS, 1'b0, 32'h0);
    end while (rd[1:0] !== 2'b00);
    repeat (8) @(posedge clk);
  endtask : wait_idle

  task automatic send_check(input logic [7:0] v);
    av_xfer(OFS_WORD_A, 1'b1, {24'h0, v});
    av_xfer(OFS_CTRL, 1'b1, 32'h1);
    model_reg = v;
    wait_idle();
    check(32'(switch_out), 32'(model_reg | {7'h0, force_on}), "outputs");
    check(32'(wire_word), 32'(v), "wire word");
  endtask : send_check

  task automatic wait_out(input logic [7:0] v);
    n = 0;
    while (switch_out !== v) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_out

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ==================================================================
  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("[FAIL] %0t run timed out", $time);
    tally_and_finish();
  end

  // ==================================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    av_address = 5'h00;
    av_read = 1'b0;
    av_write = 1'b0;
    av_writedata = 32'h0;
    force_on = 1'b0;
    model_reg = 8'h00;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(32'he4e2c229));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(32'(switch_out), 32'(OUT_CTRL_RST), "reset outputs");
    av_xfer(OFS_PERIOD, 1'b0, 32'h0);
    check(rd, {16'h0, PERIOD_RST}, "period reset");
    $display("test reset values done");
    // boundary and random words, force input off
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : (i == 2) ? 8'hff : (i == 3) ? 8'h00 : 8'($urandom);
      send_check(w);
      av_xfer(OFS_STATUS, 1'b0, 32'h0);
      check(rd, {16'h0, w, 8'h00}, "last word started");
    end
    $display("test words done");
    // force input against register bit zero
    for (int i = 0; i < 6; i++) begin
      force_on <= i[0];
      send_check(8'($urandom) & ((i < 2) ? 8'hfe : 8'hff));
    end
    force_on <= 1'b0;
    $display("test force done");
    // unmapped and read-only places, period clamp
    av_xfer(5'h14, 1'b1, 32'hffff_ffff);
    av_xfer(5'h14, 1'b0, 32'h0);
    check(rd, 32'h0, "unmapped read");
    av_xfer(OFS_STATUS, 1'b1, 32'hffff_ffff);
    av_xfer(OFS_STATUS, 1'b0, 32'h0);
    check(rd, {16'h0, model_reg, 8'h00}, "status write ignored");
    av_xfer(OFS_PERIOD, 1'b1, 32'h5);
    av_xfer(OFS_PERIOD, 1'b0, 32'h0);
    check(rd, {16'h0, REFRESH_MIN_US}, "period clamp");
    // a second go while a word is on the wire is held off until the gap after the frame ends
    av_xfer(OFS_CTRL, 1'b1, 32'h1);
    av_xfer(OFS_CTRL, 1'b1, 32'h1);
    check(32'(n > 60 && n < 80), 32'h1, "go held while busy");
    wait_idle();
    $display("test registers done");
    // alternating refresh at the fastest modulation rate
    av_xfer(OFS_WORD_A, 1'b1, 32'h5a);
    av_xfer(OFS_WORD_B, 1'b1, 32'ha5);
    av_xfer(OFS_CTRL, 1'b1, 32'h6);
    wait_out(8'h5a);
    wait_out(8'ha5);
    check(32'(n > 1990 && n < 2010), 32'h1, "refresh interval");
    wait_out(8'h5a);
    check(32'(n > 1990 && n < 2010), 32'h1, "refresh interval");
    av_xfer(OFS_CTRL, 1'b1, 32'h0);
    wait_idle();
    $display("test refresh done");
    // reset in mid-frame clears outputs, then a rewrite of 8'h3c turns outputs 2 to 5 on
    av_xfer(OFS_WORD_A, 1'b1, 32'hff);
    av_xfer(OFS_CTRL, 1'b1, 32'h1);
    repeat (30) @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(switch_out), 32'h0, "outputs in reset");
    check(32'({link_if.select_low, link_if.serial_clk}), 32'h2, "link idle");
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    check(32'(switch_out), 32'h0, "outputs stay off");
    send_check(8'h3c);
    $display("test reset mid-run done");
    tally_and_finish();
  end

endmodule : serial_switch_output_control_bench

// ===== bench/ssoc_asserts.sv
// concurrent checks on the serial link and the switch outputs
`timescale 1ns/1ps

module ssoc_asserts
  import ssoc_pkg::*;
(
  // system
  input wire logic              clk,
  input wire logic              rstn,
  // serial link
  input wire logic              select_low,
  input wire logic              serial_clk,
  input wire logic              serial_data,
  // switch side
  input wire logic              first_output_force_on,
  input wire logic [WORD_W-1:0] low_side_switch_output
);

  // ==================================================================
  // helper logic
  logic [3:0]        rise_cnt_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [7:0]        since_reg;
  logic              rst_seen_reg;

  // high from the first edge of a reset on, once every flop has taken its reset value
  always_ff @(posedge clk) rst_seen_reg <= !rstn;

  // counts serial clock rises inside one frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rise_cnt_reg <= 4'h0;
    else if (select_low) rise_cnt_reg <= 4'h0;
    else if ($rose(serial_clk)) rise_cnt_reg <= rise_cnt_reg + 4'h1;
  end

  // word as the device should see it, msb first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) shift_reg <= '0;
    else if (!select_low && $rose(serial_clk)) shift_reg <= {shift_reg[WORD_W-2:0], serial_data};
  end

  // cycles since the last select rise, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) since_reg <= 8'hff;
    else if ($rose(select_low)) since_reg <= 8'h00;
    else if (since_reg != 8'hff) since_reg <= since_reg + 8'h01;
  end

  // ==================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_reset_clears: assert property (disable iff (1'b0)
    !rstn && rst_seen_reg |-> low_side_switch_output == '0 && select_low && !serial_clk)
    else $error("outputs or link not idle in reset");
  chk_idle_clk_low: assert property (select_low |-> !serial_clk)
    else $error("serial clock high while deselected");
  chk_lead_time: assert property ($fell(select_low) |-> !serial_clk)
    else $error("clock rose with select fall");
  chk_lag_time: assert property ($rose(select_low) |-> !$past(serial_clk) && !$past(serial_clk, 2))
    else $error("select rose too soon after last clock fall");
  chk_gap_time: assert property ($rose(select_low) |-> select_low[*4])
    else $error("gap between words too short");
  chk_eight_clocks: assert property ($rose(select_low) |-> rise_cnt_reg == 4'h8)
    else $error("frame without exactly eight clocks");
  chk_word_lands: assert property ($rose(select_low) |-> ##[3:6]
    low_side_switch_output[WORD_W-1:1] == shift_reg[WORD_W-1:1])
    else $error("shifted word not on outputs");
  chk_out_timing: assert property ($changed(low_side_switch_output[WORD_W-1:1])
    |-> since_reg >= 8'h02 && since_reg <= 8'h05)
    else $error("outputs changed away from a word latch");
  chk_force_on: assert property (first_output_force_on[*6] |-> low_side_switch_output[0])
    else $error("first output off while forced");
  chk_data_stable: assert property (serial_clk && $past(serial_clk) |-> $stable(serial_data))
    else $error("serial data moved while clock high");

  // main scenarios reached
  cov_frame: cover property ($rose(select_low) && rise_cnt_reg == 4'h8);
  cov_force: cover property (first_output_force_on && low_side_switch_output[0]);
  cov_change: cover property ($changed(low_side_switch_output));

endmodule : ssoc_asserts

// ===== hdl/ssoc_device.sv
// switch device end: serial receiver, output control register, outputs
`timescale 1ns/1ps

module ssoc_device
  import ssoc_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        rstn,
  // serial link
  ssoc_if.dev_mp           link,
  // switch side
  input  wire logic        first_output_force_on,
  output logic [WORD_W-1:0] low_side_switch_output
);

  // ==================================================================
  // input synchronisers
  logic [3:0]        pins_s;
  logic              sel_low_s;
  logic              sclk_s;
  logic              sdata_s;
  logic              force_s;
  logic              sclk_q;
  logic              sel_q;
  logic [WORD_W-1:0] shift_reg;
  logic [3:0]        nbits_reg;
  logic [WORD_W-1:0] output_switch_control_reg;
  logic              clk_rise;
  logic              sel_rise;

  ssoc_sync2 #(.W(4), .RST_VAL(4'h1)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({first_output_force_on, link.serial_data, link.serial_clk, link.select_low}),
    .q    (pins_s)
  );

  assign sel_low_s = pins_s[0];
  assign sclk_s    = pins_s[1];
  assign sdata_s   = pins_s[2];
  assign force_s   = pins_s[3];

  // ==================================================================
  // edge detection on the synchronised link
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      sel_q  <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      sel_q  <= sel_low_s;
    end
  end

  assign clk_rise = sclk_s & ~sclk_q & ~sel_low_s;
  assign sel_rise = sel_low_s & ~sel_q;

  // ==================================================================
  // shift register, msb first, with bit count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= OUT_CTRL_RST;
      nbits_reg <= 4'h0;
    end else if (sel_low_s) begin
      nbits_reg <= 4'h0;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[WORD_W-2:0], sdata_s};
      if (nbits_reg != 4'hf) begin
        nbits_reg <= nbits_reg + 4'h1;
      end
    end
  end

  // ==================================================================
  // output control register, loaded only by a whole eight-bit word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_switch_control_reg <= OUT_CTRL_RST;
    end else if (sel_rise && nbits_reg == 4'(WORD_W)) begin
      output_switch_control_reg <= shift_reg;
    end
  end

  // ==================================================================
  // switch outputs: one bit each, first output may be forced on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_side_switch_output <= OUT_CTRL_RST;
    end else begin
      low_side_switch_output <= output_switch_control_reg |
                                {{(WORD_W-1){1'b0}}, force_s};
    end
  end

endmodule : ssoc_device

// ===== hdl/ssoc_host.sv
// host end: avalon-mm registers, refresh timer and serial word sender
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

module ssoc_host
  import ssoc_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // serial link
  ssoc_if.host_mp          link
);

  // ==================================================================
  // declarations
  logic [WORD_W-1:0] word_a_reg;
  logic [WORD_W-1:0] word_b_reg;
  logic              auto_reg;
  logic              pwm_reg;
  logic [15:0]       period_reg;
  logic [WORD_W-1:0] sent_reg;
  logic              pend_reg;
  logic              alt_reg;
  logic [4:0]        us_cnt_reg;
  logic              us_tick_reg;
  logic [15:0]       refresh_cnt_reg;
  ssoc_host_state_t  state_reg;
  logic [7:0]        cnt_reg;
  logic [2:0]        nbits_reg;
  logic [WORD_W-1:0] shift_reg;
  logic              sel_low_reg;
  logic              sclk_reg;
  logic              sdata_reg;
  logic              busy;
  logic              go_wr;
  logic              accept;
  logic              commit;
  logic              refresh_fire;
  logic              start;
  logic [WORD_W-1:0] word_next;

  // read multiplexer for the register map
  function automatic logic [31:0] read_mux(input logic [4:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFS_WORD_A: r[WORD_W-1:0] = word_a_reg;
      OFS_WORD_B: r[WORD_W-1:0] = word_b_reg;
      OFS_CTRL: begin
        r[CTRL_AUTO_BIT] = auto_reg;
        r[CTRL_PWM_BIT]  = pwm_reg;
      end
      OFS_PERIOD: r[15:0] = period_reg;
      OFS_STATUS: begin
        r[STAT_BUSY_BIT] = busy;
        r[STAT_PEND_BIT] = pend_reg;
        r[STAT_SENT_LSB +: WORD_W] = sent_reg;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  // ==================================================================
  // bus handshake: one wait cycle, go is stalled while a word is queued or being sent
  assign busy   = (state_reg != SSOC_IDLE);
  assign go_wr  = avs_write && (avs_address == OFS_CTRL) && avs_writedata[CTRL_GO_BIT];
  assign accept = (avs_read || avs_write) && avs_waitrequest && !(go_wr && (pend_reg || busy));
  assign commit = (avs_read || avs_write) && !avs_waitrequest;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !accept;
      if (accept && avs_read) begin
        avs_readdata <= read_mux(avs_address);
      end
    end
  end

  // ==================================================================
  // register writes take effect at the committing edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_a_reg <= WORD_RST;
      word_b_reg <= WORD_RST;
      auto_reg   <= 1'b0;
      pwm_reg    <= 1'b0;
      period_reg <= PERIOD_RST;
    end else if (commit && avs_write) begin
      unique case (avs_address)
        OFS_WORD_A: word_a_reg <= avs_writedata[WORD_W-1:0];
        OFS_WORD_B: word_b_reg <= avs_writedata[WORD_W-1:0];
        OFS_CTRL: begin
          auto_reg <= avs_writedata[CTRL_AUTO_BIT];
          pwm_reg  <= avs_writedata[CTRL_PWM_BIT];
        end
        OFS_PERIOD: begin
          // shorter intervals would modulate faster than allowed
          if (avs_writedata[15:0] < REFRESH_MIN_US) begin
            period_reg <= REFRESH_MIN_US;
          end else begin
            period_reg <= avs_writedata[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ==================================================================
  // microsecond enable divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      us_cnt_reg  <= 5'h00;
      us_tick_reg <= 1'b0;
    end else if (us_cnt_reg == 5'(CYC_PER_US - 1)) begin
      us_cnt_reg  <= 5'h00;
      us_tick_reg <= 1'b1;
    end else begin
      us_cnt_reg  <= us_cnt_reg + 5'h01;
      us_tick_reg <= 1'b0;
    end
  end

  // ==================================================================
  // refresh timer: one word per interval, two per modulation period
  assign refresh_fire = auto_reg && us_tick_reg && (refresh_cnt_reg >= period_reg - 16'h0001);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refresh_cnt_reg <= 16'h0000;
    end else if (!auto_reg || refresh_fire) begin
      refresh_cnt_reg <= 16'h0000;
    end else if (us_tick_reg) begin
      refresh_cnt_reg <= refresh_cnt_reg + 16'h0001;
    end
  end

  // ==================================================================
  // pending request: a new request wins over the clear on start
  assign start = pend_reg && (state_reg == SSOC_IDLE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= refresh_fire || (commit && go_wr) || (pend_reg && !start);
    end
  end

  // word choice: alternate a and b each send when modulating
  assign word_next = (pwm_reg && alt_reg) ? word_b_reg : word_a_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alt_reg  <= 1'b0;
      sent_reg <= WORD_RST;
    end else if (start) begin
      alt_reg  <= pwm_reg && !alt_reg;
      sent_reg <= word_next;
    end
  end

  // ==================================================================
  // link sequencer: lead, eight clocks, lag, gap
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= SSOC_IDLE;
      cnt_reg     <= 8'h00;
      nbits_reg   <= 3'h0;
      shift_reg   <= WORD_RST;
      sel_low_reg <= 1'b1;
      sclk_reg    <= 1'b0;
      sdata_reg   <= 1'b0;
    end else begin
      unique case (state_reg)
        SSOC_IDLE: begin
          if (start) begin
            sel_low_reg <= 1'b0;
            shift_reg   <= word_next;
            sdata_reg   <= word_next[WORD_W-1];
            nbits_reg   <= 3'h0;
            cnt_reg     <= LEAD_LD;
            state_reg   <= SSOC_LEAD;
          end
        end
        SSOC_LEAD: begin
          if (cnt_reg == 8'h00) begin
            sclk_reg  <= 1'b1;
            cnt_reg   <= HALF_LD;
            state_reg <= SSOC_HIGH;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        SSOC_HIGH: begin
          if (cnt_reg == 8'h00) begin
            sclk_reg <= 1'b0;
            if (nbits_reg == 3'(WORD_W - 1)) begin
              cnt_reg   <= LAG_LD;
              state_reg <= SSOC_LAG;
            end else begin
              nbits_reg <= nbits_reg + 3'h1;
              shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
              sdata_reg <= shift_reg[WORD_W-2];
              cnt_reg   <= HALF_LD;
              state_reg <= SSOC_LOW;
            end
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        SSOC_LOW: begin
          if (cnt_reg == 8'h00) begin
            sclk_reg  <= 1'b1;
            cnt_reg   <= HALF_LD;
            state_reg <= SSOC_HIGH;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        SSOC_LAG: begin
          if (cnt_reg == 8'h00) begin
            sel_low_reg <= 1'b1;
            cnt_reg     <= GAP_LD;
            state_reg   <= SSOC_GAP;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        SSOC_GAP: begin
          // clock stays low while deselected
          if (cnt_reg == 8'h00) begin
            state_reg <= SSOC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= SSOC_IDLE;
      endcase
    end
  end

  // link pins straight from flops
  assign link.select_low  = sel_low_reg;
  assign link.serial_clk  = sclk_reg;
  assign link.serial_data = sdata_reg;

endmodule : ssoc_host

// ===== hdl/ssoc_if.sv
// three-wire serial link between host and switch device
`timescale 1ns/1ps

interface ssoc_if;
  logic select_low;   // active-low word select
  logic serial_clk;   // clock made by the host
  logic serial_data;  // data toward the device

  modport host_mp (
    output select_low,
    output serial_clk,
    output serial_data
  );

  modport dev_mp (
    input select_low,
    input serial_clk,
    input serial_data
  );
endinterface : ssoc_if

// ===== hdl/ssoc_pkg.sv
// constants and types shared by both ends of the serial switch link
package ssoc_pkg;

  // ==================================================================
  // word and clock
  localparam int CLK_MHZ    = 20;             // system clock rate
  localparam int CYC_PER_US = CLK_MHZ;
  localparam int WORD_W     = 8;

  // ==================================================================
  // link timing in ns, as printed, and derived cycle counts
  localparam int SEL_LEAD_NS = 10;            // select low to first clock rise
  localparam int SEL_LAG_NS  = 80;            // last clock fall to select rise
  localparam int GAP_NS      = 170;           // select high between words
  localparam int HALF_NS     = 200;           // half period of the made clock

  // least time to cycles: round up, never below one
  function automatic int ssoc_ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ssoc_ns_to_cyc

  localparam logic [7:0] LEAD_LD = 8'(ssoc_ns_to_cyc(SEL_LEAD_NS) - 1);
  localparam logic [7:0] LAG_LD  = 8'(ssoc_ns_to_cyc(SEL_LAG_NS) - 1);
  localparam logic [7:0] GAP_LD  = 8'(ssoc_ns_to_cyc(GAP_NS) - 1);
  localparam logic [7:0] HALF_LD = 8'(ssoc_ns_to_cyc(HALF_NS) - 1);

  // ==================================================================
  // modulation limits
  localparam int          PWM_MAX_HZ     = 5000;
  localparam logic [15:0] REFRESH_MIN_US = 16'(1000000 / (2 * PWM_MAX_HZ));

  // ==================================================================
  // host register map, byte addresses
  localparam logic [4:0] OFS_WORD_A = 5'h00;
  localparam logic [4:0] OFS_WORD_B = 5'h04;
  localparam logic [4:0] OFS_CTRL   = 5'h08;
  localparam logic [4:0] OFS_PERIOD = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_PWM_BIT  = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_SENT_LSB = 8;

  localparam logic [7:0]  WORD_RST     = 8'h00;
  localparam logic [15:0] PERIOD_RST   = 16'h0064;
  localparam logic [7:0]  OUT_CTRL_RST = 8'h00;

  // ==================================================================
  // host link sequencer states, one bit apart on each step except HIGH to LAG and GAP to IDLE
  typedef enum logic [2:0] {
    SSOC_IDLE = 3'h0,
    SSOC_LEAD = 3'h1,
    SSOC_HIGH = 3'h3,
    SSOC_LOW  = 3'h2,
    SSOC_LAG  = 3'h6,
    SSOC_GAP  = 3'h7
  } ssoc_host_state_t;

endpackage : ssoc_pkg

// ===== hdl/ssoc_sync2.sv
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps

module ssoc_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // system
  input  wire logic         clk,
  input  wire logic         rstn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first flop feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : ssoc_sync2
